// [include/mhb_pkg.sv]
// package for the muxed host bus read path: constants and carriers
package mhb_pkg;

   // address widths and pin positions
   localparam int          ADDR_W       = 10;       // byte address bits
   localparam int          ENDIAN_PIN   = 10;       // one above addr bit 9
   localparam int          DIRECT_PIN   = 11;       // two above addr bit 9
   localparam int          DUAL_HI_LSB  = 8;        // dual phase high part
   localparam logic [7:0]  LANE_MASK_8  = 8'h03;
   localparam logic [1:0]  LANES_8      = 2'h3;     // last lane index, 8-bit
   localparam logic [1:0]  LANES_16     = 2'h1;     // last lane index, 16-bit

   // reset values
   localparam logic [9:0]  ADDR_RST     = 10'h000;
   localparam logic [15:0] DOUT_RST     = 16'h0000;
   localparam logic [31:0] WORD_RST     = 32'h00000000;

   // fifo depth default
   localparam int          FIFO_DEPTH   = 16;

   // host strap configuration
   typedef struct packed {
      logic latch_strobe_polarity_cfg;  // 1: latch strobes active high
      logic select_polarity_cfg;        // 1: chip select active high
      logic read_dir_polarity_cfg;      // 1: read / direction active high
      logic write_enable_polarity_cfg;  // 1: write / enable active high
      logic strobe_scheme_cfg;          // 1: enable plus direction
      logic latch_qualify_cfg;          // 1: strobes need chip select
      logic dual_phase_cfg;             // 1: dual phase latching
      logic bus16_cfg;                  // 1: 16-bit data bus
   } mhb_straps_s;

   // latched address state
   typedef struct packed {
      logic [9:0] addr;                 // byte address
      logic       big_endian;
      logic       fifo_direct;
   } mhb_addr_s;

   // internal read request
   typedef struct packed {
      logic       req;
      logic [9:0] addr;
      logic       fifo_direct;
      logic       pop;                  // change-on-read / fifo pop
   } mhb_rdreq_s;

endpackage : mhb_pkg

// [src/mhb_read_path.sv]
// muxed host bus read path: strobes, address latch, read assembly, fifo
//
// Operation
// R1: host reads every lane of a dword with two or four reads, any order
// R2: only read count toward completion; repeated lanes are not detected
// R3: separate read lane counter advances at each read trailing edge
// R4: final lane read issues exactly one internal read
// R5: read lane counter clears when power leaves full power state
// R6: hardware-event bits held from read cycle start
// R7: multi-lane live registers lock first lane, unlock last or power exit
// R8: pops and change-on-read effects occur at read end, last lane only
// R9: events during hold or lock are deferred until read sequence ends
// R10: pollable registers allow single repeated lane reads; here every read counts as a lane, fetch only at the first
// R11: latched endian bit low selects little, high selects big endian
// R12: internal words little endian; lanes reordered by endian and addr
// R13: status fifo normal read advances; peek read does not
// R14: fifo direct reads come from receive fifo, only lane bits decoded
// R15: fifo direct byte order follows latched endian; assembly unchanged
// R16: fifo direct select stays latched until reset or new address
// R17: each control signal polarity set by straps at reset
// R18: strap selects separate strobes or enable plus direction
// R19: strap selects whether latch strobes need chip select
// R20: dual phase strobes any order, omitted parts retained
// R21: single phase latch may be omitted; last address reused
// R22: host keeps address cycles inside one dword until complete
// R23: endian from pin above top address bit, direct two above
// R24: 16-bit latched value is word address, converted to byte address
// R25: single cycle internal read request, returned word captured
// R26: host strobes synchronized before edge detection
`timescale 1ns/10ps

// receive data fifo: flop storage, valid/ready both sides
module mhb_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = mhb_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } mhb_fifo_s;

   mhb_fifo_s               st;
   mhb_fifo_s               next_st;
   logic [WIDTH-1:0]        mem [DEPTH];
   logic                    push;
   logic                    pop;

   assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (st.cnt != '0);
   assign out_data_o  = mem[st.rd];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // pointer and count update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr = st.wr + AW'(1);
      end
      if (pop) begin
         next_st.rd = st.rd + AW'(1);
      end
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // state register and storage
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
      if (push) begin
         mem[st.wr] <= in_data_i;
      end
   end
endmodule : mhb_fifo

// top: host facing read path of the muxed bus unit
module mhb_read_path
   import mhb_pkg::*;
(
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   // straps and power state
   input  wire mhb_straps_s  straps_i,
   input  wire logic         full_power_state_i,
   // host pins
   input  wire logic         addr_latch_low_strobe_i,
   input  wire logic         addr_latch_high_strobe_i,
   input  wire logic         chip_select_i,
   input  wire logic         read_dir_i,        // read strobe or direction
   input  wire logic         cycle_enable_in_i, // write strobe or enable
   input  wire logic [15:0]  ad_i,
   output logic [15:0]       ad_o,
   output logic [15:0]       ad_oe_o,
   // internal register fabric
   output mhb_rdreq_s        rd_req_o,
   input  wire logic [31:0]  rd_data_i,
   input  wire logic         rd_peek_i,         // address is a peek alias
   output logic              live_hold_o,
   output logic              live_lock_o,
   output logic              defer_release_o,
   output mhb_addr_s         latched_addr_o,
   // receive data fifo fill side
   input  wire logic         rx_valid_i,
   output logic              rx_ready_o,
   input  wire logic [31:0]  rx_data_i
);

   typedef struct packed {
      logic        strap_ok;
      logic        sync_ok;      // stage two holds real pin samples
      mhb_straps_s straps;
      logic [4:0]  s1;           // sync stage one: lo, hi, cs, rd, wr
      logic [4:0]  s2;
      logic [15:0] ad_q;         // pins sampled with the strobes
      logic [15:0] ad_q2;
      logic        lo_act;
      logic        hi_act;
      logic        rd_act;
      mhb_addr_s   la;
      logic [1:0]  rd_cnt;
      logic        lock;
      logic        defer;
      logic [31:0] word;
      logic [15:0] dout;
      logic [15:0] oe;
      mhb_rdreq_s  req;
      logic        rx_pop;
   } mhb_state_s;

   mhb_state_s  st;
   mhb_state_s  next_st;
   logic        rx_valid;
   logic [31:0] rx_data;

   // active level after polarity straps
   function automatic logic act(input logic pin, input logic pol);
      act = ~(pin ^ pol);
   endfunction : act

   // select a host lane from a little endian word
   function automatic logic [15:0] lane_sel(input logic [31:0] w,
                                            input logic [1:0] a,
                                            input logic be,
                                            input logic b16);
      logic [1:0] idx;
      idx = 2'h0;
      if (b16) begin
         idx = {a[1], 1'b0};
         if (be) begin
            lane_sel = {w[idx*8 +: 8], w[(idx+1)*8 +: 8]};
         end else begin
            lane_sel = w[idx*8 +: 16];
         end
      end else begin
         idx = be ? ~a : a;
         lane_sel = {8'h00, w[idx*8 +: 8]};
      end
   endfunction : lane_sel

   mhb_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .in_valid_i (rx_valid_i),
      .in_ready_o (rx_ready_o),
      .in_data_i  (rx_data_i),
      .out_valid_o(rx_valid),
      .out_ready_i(st.rx_pop),
      .out_data_o (rx_data)
   );

   // main sequencing
   always_comb begin
      logic cs_a;
      logic lo_a;
      logic hi_a;
      logic rd_a;
      logic lo_fall;
      logic hi_fall;
      logic rd_rise;
      logic rd_fall;
      logic [1:0] last;
      logic [9:0] base;
      cs_a = 1'b0;
      lo_a = 1'b0;
      hi_a = 1'b0;
      rd_a = 1'b0;
      lo_fall = 1'b0;
      hi_fall = 1'b0;
      rd_rise = 1'b0;
      rd_fall = 1'b0;
      last = 2'h0;
      base = ADDR_RST;
      next_st = st;
      next_st.req.req = 1'b0;
      next_st.req.pop = 1'b0;
      next_st.rx_pop  = 1'b0;
      // straps caught once after reset release
      if (!st.strap_ok) begin
         next_st.straps   = straps_i;                          // R17
         next_st.strap_ok = 1'b1;
      end
      // two flop synchronizers; stage one feeds stage two only
      next_st.s1 = {addr_latch_low_strobe_i, addr_latch_high_strobe_i,
                    chip_select_i, read_dir_i, cycle_enable_in_i};
      next_st.s2 = st.s1;                                      // R26
      next_st.sync_ok = st.strap_ok;  // no edges from reset zeros
      next_st.ad_q  = ad_i;
      next_st.ad_q2 = st.ad_q;
      cs_a = act(st.s2[2], st.straps.select_polarity_cfg);     // R17
      lo_a = act(st.s2[4], st.straps.latch_strobe_polarity_cfg)
             & (cs_a | ~st.straps.latch_qualify_cfg) & st.sync_ok; // R19
      hi_a = act(st.s2[3], st.straps.latch_strobe_polarity_cfg)
             & (cs_a | ~st.straps.latch_qualify_cfg) & st.sync_ok;
      if (st.straps.strobe_scheme_cfg) begin                   // R18
         rd_a = act(st.s2[0], st.straps.write_enable_polarity_cfg)
                & act(st.s2[1], st.straps.read_dir_polarity_cfg);
      end else begin
         rd_a = cs_a & act(st.s2[1], st.straps.read_dir_polarity_cfg);
      end
      rd_a = rd_a & st.sync_ok & full_power_state_i;
      next_st.lo_act = lo_a;
      next_st.hi_act = hi_a;
      next_st.rd_act = rd_a;
      lo_fall = st.lo_act & ~lo_a;
      hi_fall = st.hi_act & ~hi_a;
      rd_rise = ~st.rd_act & rd_a;
      rd_fall = st.rd_act & ~rd_a;
      // address latch on trailing strobe edges
      if (st.straps.dual_phase_cfg) begin                      // R20
         if (lo_fall) begin
            if (st.straps.bus16_cfg) begin                     // R24
               next_st.la.addr[8:1] = st.ad_q2[7:0];
            end else begin
               next_st.la.addr[7:0] = st.ad_q2[7:0];
            end
         end
         if (hi_fall) begin
            if (st.straps.bus16_cfg) begin
               next_st.la.addr[9]     = st.ad_q2[0];
               next_st.la.big_endian  = st.ad_q2[1];           // R23
               next_st.la.fifo_direct = st.ad_q2[2];           // R16
            end else begin
               next_st.la.addr[9:8]   = st.ad_q2[1:0];
               next_st.la.big_endian  = st.ad_q2[2];
               next_st.la.fifo_direct = st.ad_q2[3];
            end
         end
      end else if (lo_fall) begin                              // R21
         if (st.straps.bus16_cfg) begin
            next_st.la.addr        = {st.ad_q2[8:0], 1'b0};    // R24
            next_st.la.big_endian  = st.ad_q2[9];
            next_st.la.fifo_direct = st.ad_q2[10];
         end else begin
            next_st.la.addr        = st.ad_q2[9:0];
            next_st.la.big_endian  = st.ad_q2[ENDIAN_PIN];     // R23
            next_st.la.fifo_direct = st.ad_q2[DIRECT_PIN];
         end
      end
      last = st.straps.bus16_cfg ? LANES_16 : LANES_8;
      base = {st.la.addr[9:2], 2'b00};
      // read start: fetch word unless locked mid dword
      if (rd_rise) begin
         if (st.rd_cnt == 2'h0) begin
            next_st.req.req  = 1'b1;                           // R25 R10
            next_st.req.addr = st.la.fifo_direct ? ADDR_RST : base; // R14
            next_st.req.fifo_direct = st.la.fifo_direct;
            next_st.lock = (last != 2'h0);                     // R7
         end
      end
      // capture returned word one cycle after the request
      if (st.req.req) begin
         next_st.word = st.req.fifo_direct ? rx_data : rd_data_i; // R14
      end
      // drive host lane while the read is active
      if (rd_a) begin
         next_st.dout = lane_sel(st.word, st.la.addr[1:0],
                                 st.la.big_endian,
                                 st.straps.bus16_cfg);         // R11 R12 R15
         next_st.oe = st.straps.bus16_cfg ? 16'hFFFF : 16'h00FF;
      end else begin
         next_st.oe = 16'h0000;
      end
      // trailing edge: count lanes, finish dword
      if (rd_fall) begin
         if (st.rd_cnt == last) begin                          // R2
            next_st.rd_cnt   = 2'h0;
            next_st.lock     = 1'b0;                           // R7
            next_st.defer    = 1'b1;                           // R9
            next_st.req.req  = 1'b1;                           // R4
            next_st.req.pop  = ~rd_peek_i;                     // R8 R13
            next_st.req.addr = st.la.fifo_direct ? ADDR_RST : base;
            next_st.req.fifo_direct = st.la.fifo_direct;
            next_st.rx_pop   = st.la.fifo_direct & rx_valid;   // R15
         end else begin
            next_st.rd_cnt = st.rd_cnt + 2'h1;                 // R3
         end
      end else begin
         next_st.defer = 1'b0;
      end
      // leaving full power clears counter and lock
      if (!full_power_state_i) begin
         next_st.rd_cnt = 2'h0;                                // R5
         next_st.lock   = 1'b0;                                // R7
      end
   end

   // state register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state flops
   assign ad_o            = st.dout;
   assign ad_oe_o         = st.oe;
   assign rd_req_o        = st.req;
   assign live_hold_o     = st.rd_act;                         // R6
   assign live_lock_o     = st.lock;
   assign defer_release_o = st.defer;                          // R9
   assign latched_addr_o  = st.la;
endmodule : mhb_read_path

// [verif/mhb_read_path_monitor.sv]
// checker of the muxed host bus read path, bound to its top module
`timescale 1ns/10ps
module mhb_read_path_monitor
   import mhb_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   // straps, power and host pins
   input wire mhb_straps_s straps_i,
   input wire logic        full_power_state_i,
   input wire logic        chip_select_i,
   input wire logic        read_dir_i,
   input wire logic        rd_peek_i,
   // watched outputs
   input wire logic [15:0] ad_oe_o,
   input wire mhb_rdreq_s  rd_req_o,
   input wire logic        live_hold_o,
   input wire logic        live_lock_o,
   input wire logic        defer_release_o,
   input wire mhb_addr_s   latched_addr_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // raw read strobe at the pins, before any synchroniser
   logic rd_pin;
   assign rd_pin = (read_dir_i == straps_i.read_dir_polarity_cfg) &&
                   (chip_select_i == straps_i.select_polarity_cfg);

   property p_req_pulse;
      rd_req_o.req |=> !rd_req_o.req;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("internal read request longer than one cycle");
   property p_sync;
      $rose(rd_pin) |-> !rd_req_o.req [*3];
   endproperty
   a_sync: assert property (p_sync)
      else $error("read request before strobe was synchronised");
   property p_hold_req;
      $rose(live_hold_o) && !$past(live_lock_o) |-> ##[0:2] rd_req_o.req;
   endproperty
   a_hold_req: assert property (p_hold_req)
      else $error("held read without an internal read");
   property p_pop_req;
      rd_req_o.pop |-> rd_req_o.req;
   endproperty
   a_pop_req: assert property (p_pop_req)
      else $error("pop outside an internal read");
   property p_peek;
      rd_req_o.req && rd_peek_i |-> !rd_req_o.pop;
   endproperty
   a_peek: assert property (p_peek)
      else $error("peek read popped the fifo");
   property p_power;
      !full_power_state_i |-> ##[1:2] !live_lock_o;
   endproperty
   a_power: assert property (p_power)
      else $error("lock kept outside full power");
   property p_defer;
      defer_release_o |=> !defer_release_o && !live_lock_o;
   endproperty
   a_defer: assert property (p_defer)
      else $error("deferred release malformed");
   property p_oe;
      ad_oe_o != 16'h0000 |->
         ad_oe_o == (straps_i.bus16_cfg ? 16'hFFFF : 16'h00FF);
   endproperty
   a_oe: assert property (p_oe)
      else $error("wrong data lanes driven");
   property p_direct;
      rd_req_o.req && latched_addr_o.fifo_direct |-> rd_req_o.fifo_direct;
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct read not sent to the fifo");
   property p_addr;
      rd_req_o.req && !latched_addr_o.fifo_direct |->
         rd_req_o.addr == {latched_addr_o.addr[9:2], 2'b00} &&
         !rd_req_o.fifo_direct;
   endproperty
   a_addr: assert property (p_addr)
      else $error("internal read address differs from latched address");
endmodule : mhb_read_path_monitor

bind mhb_read_path mhb_read_path_monitor mhb_read_path_monitor_inst (
   .clk_sys_i, .rst_i, .straps_i, .full_power_state_i, .chip_select_i,
   .read_dir_i, .rd_peek_i, .ad_oe_o, .rd_req_o, .live_hold_o,
   .live_lock_o, .defer_release_o, .latched_addr_o);

// [verif/mhb_host_model.sv]
// host controller model: drives the multiplexed bus pins
`timescale 1ns/10ps
module mhb_host_model (
   // clock
   input  wire logic        clk_sys_i,
   // host pins, strobes active high
   output logic             ale_lo_o,
   output logic             cs_o,
   output logic             rd_o,
   output wire logic [15:0] ad_o,
   // resolved bus wire
   input  wire logic [15:0] bus_i
);
   logic        drive = 1'b0;
   logic [15:0] addr_q = 16'h0000;
   logic [15:0] idle = 16'h5A5A;

   // released bus toggles so no stale value survives
   always @(posedge clk_sys_i) idle <= ~idle;
   assign ad_o = drive ? addr_q : idle;
   initial begin
      ale_lo_o = 1'b0;
      cs_o = 1'b0;
      rd_o = 1'b0;
   end

   // one address phase; sel is chip select during the strobe
   task automatic latch(input logic [11:0] a, input logic sel);
      @(posedge clk_sys_i);
      drive <= 1'b1;
      addr_q <= {4'h0, a};
      cs_o <= sel;
      ale_lo_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      ale_lo_o <= 1'b0; // address taken on the trailing edge
      repeat (4) @(posedge clk_sys_i);
      drive <= 1'b0;
      cs_o <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
   endtask : latch

   // one read cycle: strobe, take the lane, release
   task automatic read(output logic [15:0] d);
      @(posedge clk_sys_i);
      cs_o <= 1'b1;
      rd_o <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      d = bus_i;
      cs_o <= 1'b0;
      rd_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
   endtask : read
endmodule : mhb_host_model

// [verif/test_mhb_read_path.sv]
// self-checking bench for the muxed host bus read path
`timescale 1ns/10ps
module test_mhb_read_path
   import mhb_pkg::*;
();
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   mhb_straps_s straps_i = 8'hF4; // single phase, 8-bit, qualified
   logic        full_power_state_i = 1'b1;
   logic        rd_peek_i = 1'b0;
   logic [31:0] rd_data_i = 32'h00000000;
   logic        rx_valid_i = 1'b0;
   logic [31:0] rx_data_i = 32'h00000000;
   logic        inv = 1'b0;         // inverts every host strobe
   logic        ale_lo, cs, rd, rx_ready_o;
   logic [15:0] host_ad, bus, ad_o, ad_oe_o;
   mhb_rdreq_s  rd_req_o;
   mhb_addr_s   latched_addr_o;
   int          num_errors = 0;
   int          num_checks = 0;
   int          n_pop = 0;

   always #2.5 clk_sys_i = ~clk_sys_i;
   // bus wire resolved from both drivers
   assign bus = (ad_oe_o & ad_o) | (~ad_oe_o & host_ad);
   // count fifo pops and change-on-read reads
   always @(posedge clk_sys_i)
      if (rd_req_o.req === 1'b1 && rd_req_o.pop === 1'b1) n_pop++;

   mhb_read_path mhb_read_path_inst (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .straps_i(straps_i),
      .full_power_state_i(full_power_state_i),
      .addr_latch_low_strobe_i(ale_lo ^ inv),
      .addr_latch_high_strobe_i(inv),
      .chip_select_i(cs ^ inv), .read_dir_i(rd ^ inv),
      .cycle_enable_in_i((cs & rd) ^ inv),
      .ad_i(bus), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .rd_req_o(rd_req_o),
      .rd_data_i(rd_data_i), .rd_peek_i(rd_peek_i), .live_hold_o(),
      .live_lock_o(), .defer_release_o(), .latched_addr_o(latched_addr_o),
      .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
      .rx_data_i(rx_data_i));
   mhb_host_model h (
      .clk_sys_i(clk_sys_i), .ale_lo_o(ale_lo), .cs_o(cs), .rd_o(rd),
      .ad_o(host_ad), .bus_i(bus));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : check

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // read one dword in lane order 2,1,0,3 and judge every byte
   task automatic dword(input logic [9:0] base, input logic be,
                        input logic dir, input logic [31:0] w);
      logic [15:0] d;
      logic [1:0]  ln;
      int          p0;
      @(posedge clk_sys_i);
      rd_data_i <= dir ? ~w : w;
      p0 = n_pop;
      for (int i = 0; i < 4; i++) begin
         ln = 2'(i * 3 + 2);
         h.latch({dir, be, base | 10'(ln)}, 1'b1);
         h.read(d);
         check(32'(d[7:0]), be ? w[8*(3-ln)+:8] : w[8*ln+:8], "byte");
         if (i == 2) check(32'(n_pop - p0), 0, "early pop");
      end
      check(32'(n_pop - p0), {31'h0, !rd_peek_i}, "pop count");
   endtask : dword

   // address pins, endian pin and chip select qualification
   task automatic qualify;
      h.latch(12'h5A3, 1'b1);
      check(latched_addr_o, {10'h1A3, 1'b1, 1'b0}, "latched");
      h.latch(12'h0C4, 1'b0);
      check(latched_addr_o, {10'h1A3, 1'b1, 1'b0}, "unqualified");
   endtask : qualify

   // two lanes read, power leaves full power, then a whole dword
   task automatic power_cut;
      logic [15:0] d;
      h.latch(12'h040, 1'b1);
      h.read(d);
      h.latch(12'h041, 1'b1);
      h.read(d);
      @(posedge clk_sys_i);
      full_power_state_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      full_power_state_i <= 1'b1;
      dword(10'h040, 1'b0, 1'b0, 32'h3C5A96E1);
   endtask : power_cut

   // fill the receive fifo until refused, drain it by direct reads
   task automatic rx_fill_drain;
      @(posedge clk_sys_i);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         rx_valid_i <= 1'b1;
         rx_data_i <= 32'hA5C30F00 + 32'(i);
         @(posedge clk_sys_i iff rx_ready_o === 1'b1);
      end
      rx_valid_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      check(32'(rx_ready_o), 0, "full fifo refusal");
      for (int i = 0; i < FIFO_DEPTH; i++)
         dword(10'h000, 1'(i), 1'b1, 32'hA5C30F00 + 32'(i));
      check(32'(rx_ready_o), 1, "fifo drained");
   endtask : rx_fill_drain

   // second reset: dual phase, 16-bit, enable plus direction, active low
   task automatic restrap;
      logic [15:0] d;
      int          p0;
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      inv <= 1'b1;
      straps_i <= 8'h0B;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd_data_i <= 32'hC3A55A3C;
      repeat (3) @(posedge clk_sys_i);
      check(latched_addr_o, 12'h000, "no latch from reset");
      p0 = n_pop;
      h.latch(12'h055, 1'b0);
      check(latched_addr_o, {10'h0AA, 2'b00}, "low phase only");
      h.read(d);
      check(32'(d), 32'h0000C3A5, "upper word");
      h.latch(12'h054, 1'b0);
      h.read(d);
      check(32'(d), 32'h00005A3C, "lower word");
      check(32'(n_pop - p0), 1, "one pop per dword");
   endtask : restrap

   // main sequence
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      qualify();
      dword(10'h104, 1'b0, 1'b0, 32'h44332211);
      dword(10'h104, 1'b1, 1'b0, 32'h88776655);
      @(posedge clk_sys_i);
      rd_peek_i <= 1'b1;
      dword(10'h0A8, 1'b0, 1'b0, 32'h12345678);
      @(posedge clk_sys_i);
      rd_peek_i <= 1'b0;
      power_cut();
      rx_fill_drain();
      restrap();
      give_verdict();
   end

   // watchdog against a hung handshake
   initial begin
      #100000;
      num_errors++;
      give_verdict();
   end
endmodule : test_mhb_read_path
